// ---- design/fspc_core.sv ----
/* Five-stage in-order pipeline control with bypass, muldiv timing
   and cache miss stalls. Assumes cache arrays
   and the bus side run on clock_in; cache hits answer in the same cycle, the bus some cycles later. */
`timescale 1ns/1ps
`default_nettype none
module fspc_core #(
    parameter bit SMALL_MULDIV = 1'b0
) (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    output logic             fetch_req_out,
    output logic [31:0]      fetch_addr_out,
    input  wire logic        icache_hit_in,
    input  wire logic [31:0] icache_data_in,
    output logic             dcache_rd_out,
    output logic             dcache_wr_out,
    output logic [31:0]      dcache_addr_out,
    output logic [31:0]      dcache_wdata_out,
    input  wire logic        dcache_hit_in,
    input  wire logic [31:0] dcache_rdata_in,
    output logic             bus_req_out,
    output logic             bus_is_data_out,
    output logic [31:0]      bus_addr_out,
    input  wire logic        bus_busy_in,
    input  wire logic        bus_rdata_valid_in,
    input  wire logic [31:0] bus_rdata_in,
    output logic             rf_wr_en_out,
    output logic [4:0]       rf_wr_idx_out,
    output logic [31:0]      rf_wr_data_out,
    output logic [31:0]      accumulator_high_out,
    output logic [31:0]      accumulator_low_out
);
    import fspc_pkg::*;

    typedef struct packed {
        logic [31:0]       pc;
        logic              e_valid;
        logic              e_imiss;
        logic [31:0]       e_instr;
        logic [31:0]       e_pc;
        logic              m_valid;
        fspc_op_t          m_op;
        logic [4:0]        m_rd;
        logic [31:0]       m_a;
        logic [31:0]       m_b;
        logic [31:0]       m_res;
        logic [5:0]        m_hold;
        logic              a_valid;
        logic              a_dmiss;
        logic [4:0]        a_rd;
        logic [31:0]       a_res;
        logic [1:0]        a_off;
        logic              w_valid;
        logic [4:0]        w_rd;
        logic [31:0]       w_res;
        logic              md_m;
        fspc_op_t          md_op;
        logic [31:0]       md_x;
        logic [31:0]       md_y;
        logic [5:0]        md_cnt;
        logic              md_a_v;
        fspc_op_t          md_a_op;
        logic              md_sx;
        logic              md_sy;
        logic [63:0]       md_p;
        logic              md_w_v;
        logic [63:0]       md_w;
        logic [63:0]       acc;
        logic              i_pend;
        logic              i_sent;
        logic              d_pend;
        logic              d_sent;
        logic [31:0][31:0] rf;
    } fspc_state_t;

    fspc_state_t q;
    fspc_state_t d;
    fspc_op_t    e_op;
    logic [31:0] rs_v;
    logic [31:0] rt_v;
    logic [31:0] imm;
    logic [63:0] mprod;
    logic [63:0] acc_cur;
    logic [31:0] ux;
    logic [31:0] uy;
    logic [31:0] uq;
    logic [31:0] ur;
    logic        e_md;
    logic        ld_use;
    logic        stall_a;
    logic        stall_m;
    logic        stall_e;
    logic        taken;
    logic        sel_any;
    logic        bus_take;

    function automatic fspc_op_t op_of(input logic [31:0] ins);
        return fspc_op_t'(ins[OP_LSB +: 4]);
    endfunction : op_of

    function automatic logic [4:0] dest_of(input logic [31:0] ins);
        case (op_of(ins))
            OP_ADD, OP_SUB, OP_AND, OP_OR,
            OP_MULTIPLY_TO_GENERAL_REGISTER: return ins[RD_LSB +: 5];
            OP_LOAD: return ins[RT_LSB +: 5];
            default: return 5'h00;
        endcase
    endfunction : dest_of

    // Operand size is judged from rt only
    function automatic logic is_short(input logic [31:0] v);
        return v[31:16] == {16{v[15]}};
    endfunction : is_short

    function automatic logic [63:0] smul(input logic [31:0] x, input logic [31:0] y);
        logic [63:0] ex;
        logic [63:0] ey;
        ex = {{32{x[31]}}, x};
        ey = {{32{y[31]}}, y};
        return ex * ey;
    endfunction : smul

    function automatic logic [31:0] align_word(input logic [31:0] v, input logic [1:0] off);
        return v >> {off, 3'b000};
    endfunction : align_word

    // Youngest copy wins; memory-stage loads and multiplies are interlocked instead
    function automatic logic [31:0] operand(input fspc_state_t s, input logic [4:0] idx);
        logic [31:0] v;
        v = s.rf[idx];
        if (s.w_valid && s.w_rd == idx) v = s.w_res;
        if (s.a_valid && !s.a_dmiss && s.a_rd == idx) v = s.a_res;
        if (s.m_valid && s.m_rd == idx && s.m_op != OP_LOAD
            && s.m_op != OP_MULTIPLY_TO_GENERAL_REGISTER) v = s.m_res;
        if (idx == 5'h00) v = 32'h0000_0000;
        return v;
    endfunction : operand

    always_comb begin
        d = q;
        e_op = op_of(q.e_instr);
        rs_v = operand(q, q.e_instr[RS_LSB +: 5]);                       // [RQ2] [RQ3]
        rt_v = operand(q, q.e_instr[RT_LSB +: 5]);                       // [RQ3]
        imm = {{16{q.e_instr[15]}}, q.e_instr[15:0]};
        mprod = smul(q.m_a, q.m_b);
        acc_cur = q.md_w_v ? q.md_w : q.acc;
        e_md = e_op == OP_MULTIPLY_TO_ACCUMULATOR || e_op == OP_DIVIDE
            || e_op == OP_MULTIPLY_ADD_ACCUMULATE || e_op == OP_MULTIPLY_SUBTRACT_ACCUMULATE;
        ld_use = q.m_valid && q.m_rd != 5'h00
            && (q.m_op == OP_LOAD || q.m_op == OP_MULTIPLY_TO_GENERAL_REGISTER)
            && (q.m_rd == q.e_instr[RS_LSB +: 5] || q.m_rd == q.e_instr[RT_LSB +: 5]);
        stall_a = q.a_valid && q.a_dmiss;                                // [RQ21]
        stall_m = stall_a || (q.m_valid && q.m_hold != 6'h00);           // [RQ23]
        stall_e = stall_m || (q.e_valid && (q.e_imiss || ld_use || (e_md && q.md_m))); // [RQ18]
        taken = q.e_valid && !q.e_imiss && e_op == OP_BRANCH_EQ && rs_v == rt_v; // [RQ5]
        ux = q.md_x[31] ? 32'h0000_0000 - q.md_x : q.md_x;
        uy = q.md_y[31] ? 32'h0000_0000 - q.md_y : q.md_y;
        uq = (uy == 32'h0000_0000) ? 32'hFFFF_FFFF : ux / uy;
        ur = (uy == 32'h0000_0000) ? ux : ux % uy;

        // Address select: data misses first, one refill outstanding at a time
        sel_any = (q.d_pend || q.i_pend) && !q.i_sent && !q.d_sent;
        bus_take = sel_any && !bus_busy_in;                              // [RQ19]
        if (bus_take) begin
            if (q.d_pend) begin
                d.d_pend = 1'b0;
                d.d_sent = 1'b1;
            end else begin
                d.i_pend = 1'b0;
                d.i_sent = 1'b1;
            end
        end

        // Writeback
        if (q.w_valid && q.w_rd != 5'h00) d.rf[q.w_rd] = q.w_res;     // [RQ17]
        d.w_valid = q.a_valid && !stall_a;                               // [RQ1]
        d.w_rd = q.a_rd;
        d.w_res = q.a_res;

        // Align / accumulate
        if (stall_a) begin
            if (q.d_sent && bus_rdata_valid_in) begin                    // [RQ24]
                d.a_res = align_word(bus_rdata_in, q.a_off);             // [RQ22] [RQ13]
                d.a_dmiss = 1'b0;
                d.d_sent = 1'b0;
            end
        end else if (stall_m) begin
            d.a_valid = 1'b0;
        end else begin
            d.a_valid = q.m_valid;
            d.a_rd = q.m_rd;
            d.a_off = q.m_res[1:0];
            d.a_res = q.m_res;
            d.a_dmiss = 1'b0;
            if (q.m_op == OP_LOAD) begin                                 // [RQ7]
                if (dcache_hit_in) begin
                    d.a_res = align_word(dcache_rdata_in, q.m_res[1:0]); // [RQ13]
                end else begin
                    d.a_dmiss = q.m_valid;                               // [RQ21]
                    d.d_pend = q.m_valid;
                end
            end else if (q.m_op == OP_MULTIPLY_TO_GENERAL_REGISTER) begin
                d.a_res = mprod[31:0];                                   // [RQ14]
            end
        end

        // Memory
        if (stall_m) begin
            if (q.m_hold != 6'h00) d.m_hold = q.m_hold - 6'h01;        // [RQ8] [RQ9]
        end else if (stall_e) begin
            d.m_valid = 1'b0;
            d.m_op = OP_NOP;
        end else begin
            d.m_valid = q.e_valid;
            d.m_op = q.e_valid ? e_op : OP_NOP;
            d.m_rd = dest_of(q.e_instr);
            d.m_a = rs_v;
            d.m_b = rt_v;
            d.m_hold = 6'h00;
            d.m_res = 32'h0000_0000;
            case (e_op)                                                  // [RQ4]
                OP_ADD: d.m_res = rs_v + rt_v;
                OP_SUB: d.m_res = rs_v - rt_v;
                OP_AND: d.m_res = rs_v & rt_v;
                OP_OR: d.m_res = rs_v | rt_v;
                OP_LOAD, OP_STORE: d.m_res = rs_v + imm;
                OP_MULTIPLY_TO_GENERAL_REGISTER: begin
                    if (SMALL_MULDIV) d.m_hold = SMALL_MULTIPLY_TO_ACCUMULATOR_HOLD;       // [RQ12]
                    else if (is_short(rt_v)) d.m_hold = FAST_GPR_SHORT_HOLD; // [RQ8]
                    else d.m_hold = FAST_GPR_FULL_HOLD;                  // [RQ9]
                end
                default: d.m_res = 32'h0000_0000;
            endcase
        end

        // Muldiv pipeline runs on through integer stalls
        d.md_a_v = 1'b0;
        d.md_w_v = q.md_a_v;
        if (q.md_w_v) d.acc = q.md_w;                                    // [RQ15] [RQ16]
        if (q.md_a_v) begin
            case (q.md_a_op)
                OP_MULTIPLY_ADD_ACCUMULATE: d.md_w = acc_cur + q.md_p;  // [RQ15]
                OP_MULTIPLY_SUBTRACT_ACCUMULATE: d.md_w = acc_cur - q.md_p;
                OP_DIVIDE: begin                                         // [RQ16]
                    d.md_w[63:32] = q.md_sx ? 32'h0000_0000 - q.md_p[63:32] : q.md_p[63:32];
                    d.md_w[31:0] = (q.md_sx ^ q.md_sy) ? 32'h0000_0000 - q.md_p[31:0]
                                                        : q.md_p[31:0];
                end
                default: d.md_w = q.md_p;
            endcase
        end
        if (q.md_m) begin
            if (q.md_cnt != 6'h00) begin
                d.md_cnt = q.md_cnt - 6'h01;                             // [RQ10] [RQ11]
            end else begin
                d.md_m = 1'b0;
                d.md_a_v = 1'b1;
                d.md_a_op = q.md_op;
                d.md_sx = q.md_x[31];
                d.md_sy = q.md_y[31];
                d.md_p = (q.md_op == OP_DIVIDE) ? {ur, uq} : smul(q.md_x, q.md_y);
            end
        end
        if (!stall_e && q.e_valid && !q.e_imiss && e_md) begin           // [RQ6]
            d.md_m = 1'b1;
            d.md_op = e_op;
            d.md_x = rs_v;
            d.md_y = rt_v;
            if (e_op == OP_DIVIDE) d.md_cnt = DIVIDE_HOLD;              // [RQ11] [RQ12]
            else if (SMALL_MULDIV) d.md_cnt = (e_op == OP_MULTIPLY_TO_ACCUMULATOR)
                                               ? SMALL_MULTIPLY_TO_ACCUMULATOR_HOLD : SMALL_MACC_HOLD; // [RQ12]
            else d.md_cnt = is_short(rt_v) ? FAST_ACC_SHORT_HOLD : FAST_ACC_FULL_HOLD; // [RQ10]
        end

        // Execute register and fetch
        if (stall_e) begin
            if (q.e_imiss && q.i_sent && bus_rdata_valid_in) begin
                d.e_instr = bus_rdata_in;                                // [RQ20]
                d.e_imiss = 1'b0;
                d.i_sent = 1'b0;
            end
        end else begin
            d.e_valid = 1'b1;
            d.e_pc = q.pc;
            d.e_instr = icache_data_in;
            d.e_imiss = !icache_hit_in;                                  // [RQ18]
            d.i_pend = !icache_hit_in;
            d.pc = taken ? q.e_pc + PC_STEP + {imm[29:0], 2'b00} : q.pc + PC_STEP; // [RQ5]
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.pc <= RESET_PC;
        end else begin
            q <= d;
        end
    end

    assign fetch_req_out = !stall_e;                                     // [RQ23]
    assign fetch_addr_out = q.pc;
    assign dcache_rd_out = q.m_valid && q.m_op == OP_LOAD;
    // Stores go once, to the write-through side; they wait while stall_m holds, as on an older load's data miss
    assign dcache_wr_out = q.m_valid && q.m_op == OP_STORE && !stall_m;
    assign dcache_addr_out = q.m_res;
    assign dcache_wdata_out = q.m_b;
    assign bus_req_out = bus_take;
    assign bus_is_data_out = q.d_pend;
    assign bus_addr_out = q.d_pend ? q.a_res : q.e_pc;
    assign rf_wr_en_out = q.w_valid && q.w_rd != 5'h00;
    assign rf_wr_idx_out = q.w_rd;
    assign rf_wr_data_out = q.w_res;
    assign accumulator_high_out = q.acc[63:32];
    assign accumulator_low_out = q.acc[31:0];

    logic gpr_go;
    logic acc_go;
    assign gpr_go = !stall_e && q.e_valid && e_op == OP_MULTIPLY_TO_GENERAL_REGISTER;
    assign acc_go = !stall_e && q.e_valid && !q.e_imiss && e_md && e_op != OP_DIVIDE;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_hold_one;
        q.m_valid && q.m_hold == 6'h01 ##1 q.m_hold == 6'h00;
    endsequence
    sequence s_hold_two;
        q.m_valid && q.m_hold == 6'h02 ##1 s_hold_one;
    endsequence

    property p_gpr_short;
        (gpr_go && !SMALL_MULDIV && is_short(rt_v)) |=> s_hold_one;
    endproperty
    a_gpr_short: assert property (p_gpr_short) else $error("short multiply hold wrong"); // [RQ8]
    property p_gpr_full;
        (gpr_go && !SMALL_MULDIV && !is_short(rt_v)) |=> s_hold_two;
    endproperty
    a_gpr_full: assert property (p_gpr_full) else $error("full multiply hold wrong"); // [RQ9]
    property p_acc_full;
        (acc_go && !SMALL_MULDIV && !is_short(rt_v)) |=> q.md_m [*2] ##1 (q.md_a_v && !q.md_m);
    endproperty
    a_acc_full: assert property (p_acc_full) else $error("accumulator pass wrong"); // [RQ10]
    property p_divide_len;
        (!stall_e && q.e_valid && !q.e_imiss && e_op == OP_DIVIDE) |-> ##34 q.md_a_v;
    endproperty
    a_divide_len: assert property (p_divide_len) else $error("divide length wrong"); // [RQ11] [RQ12]
    property p_gpr_result;
        (q.m_valid && q.m_op == OP_MULTIPLY_TO_GENERAL_REGISTER && !stall_m)
            |=> q.a_valid && q.a_res == $past(mprod[31:0]);
    endproperty
    a_gpr_result: assert property (p_gpr_result) else $error("multiply result lost"); // [RQ14]
    property p_rf_write;
        (q.w_valid && q.w_rd != 5'h00) |=> q.rf[$past(q.w_rd)] == $past(q.w_res);
    endproperty
    a_rf_write: assert property (p_rf_write) else $error("register write lost"); // [RQ17]
    property p_imiss_stall;
        (q.e_valid && q.e_imiss) |-> !fetch_req_out ##1 $stable(q.pc);
    endproperty
    a_imiss_stall: assert property (p_imiss_stall) else $error("fetch moved on miss"); // [RQ18]
    property p_bus_hold;
        (sel_any && bus_busy_in) |-> !bus_req_out ##1 (q.i_pend || q.d_pend);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("request left select"); // [RQ19]
    property p_irefill;
        (q.e_imiss && q.i_sent && bus_rdata_valid_in)
            |=> q.e_instr == $past(bus_rdata_in) && !q.e_imiss;
    endproperty
    a_irefill: assert property (p_irefill) else $error("critical word not taken"); // [RQ20]
    property p_dmiss_stall;
        (stall_a && !bus_rdata_valid_in) |=> q.a_valid && q.a_dmiss && !q.w_valid;
    endproperty
    a_dmiss_stall: assert property (p_dmiss_stall) else $error("align left on miss"); // [RQ21]
    property p_drefill;
        (stall_a && q.d_sent && bus_rdata_valid_in)
            |=> !q.a_dmiss && q.a_res == ($past(bus_rdata_in) >> {$past(q.a_off), 3'b000});
    endproperty
    a_drefill: assert property (p_drefill) else $error("refill not aligned"); // [RQ22]
    property p_hold_e;
        (stall_e && !q.e_imiss) |=> $stable(q.e_instr) && $stable(q.e_pc);
    endproperty
    a_hold_e: assert property (p_hold_e) else $error("stalled stage changed"); // [RQ23]
endmodule : fspc_core
`default_nettype wire

// ---- design/fspc_pkg.sv ----
/* Constants and opcode set of the five-stage pipeline control core.
   Assumes one clock domain and a synchronous active-low reset. */
// Behaviour
// RQ1: Five ordered stages: fetch, execute, memory, align, writeback.
// RQ2: Forward results to dependent instructions directly.
// RQ3: Execute reads register file, bypasses memory/align values.
// RQ4: Execute computes load/store address, starts arithmetic.
// RQ5: Execute resolves branches, picks next fetch address.
// RQ6: All multiply and divide operations start in execute.
// RQ7: Memory stage finishes arithmetic, does data lookup.
// RQ8: Short general multiply holds memory stage one clock.
// RQ9: Full general multiply holds memory stage two clocks.
// RQ10: Full accumulator multiply holds muldiv stage one clock.
// RQ11: Fast variant divide holds muldiv stage 32 clocks.
// RQ12: Small variant holds 31, 33, 32 clocks.
// RQ13: Aligner shifts loaded data to word boundary.
// RQ14: General multiply result ready in align stage.
// RQ15: Accumulate in align, accumulator pair written in writeback.
// RQ16: Divide sign-adjusts in align, pair written in writeback.
// RQ17: Arithmetic and load results written during writeback.
// RQ18: Instruction miss moves to execute, stalls there.
// RQ19: Bus select holds pending request while bus busy.
// RQ20: Instruction critical word loaded straight into execute.
// RQ21: Data miss moves to align, stalls there.
// RQ22: Data critical word aligned, forwarded immediately.
// RQ23: Stall holds earlier stages, inserts no new instructions.
// RQ24: Memory side flags miss data valid, any latency.
package fspc_pkg;
    localparam logic [31:0] RESET_PC  = 32'h0000_0000;
    localparam logic [31:0] PC_STEP   = 32'h0000_0004;
    localparam int          OP_LSB    = 28;
    localparam int          RS_LSB    = 21;
    localparam int          RT_LSB    = 16;
    localparam int          RD_LSB    = 11;
    localparam logic [5:0]  FAST_GPR_SHORT_HOLD = 6'h01;
    localparam logic [5:0]  FAST_GPR_FULL_HOLD  = 6'h02;
    localparam logic [5:0]  FAST_ACC_SHORT_HOLD = 6'h00;
    localparam logic [5:0]  FAST_ACC_FULL_HOLD  = 6'h01;
    localparam logic [5:0]  DIVIDE_HOLD         = 6'h20;
    localparam logic [5:0]  SMALL_MULTIPLY_TO_ACCUMULATOR_HOLD     = 6'h1F;
    localparam logic [5:0]  SMALL_MACC_HOLD     = 6'h21;

    typedef enum logic [3:0] {
        OP_NOP                          = 4'h0,
        OP_ADD                          = 4'h1,
        OP_SUB                          = 4'h2,
        OP_AND                          = 4'h3,
        OP_OR                           = 4'h4,
        OP_LOAD                         = 4'h5,
        OP_STORE                        = 4'h6,
        OP_BRANCH_EQ                    = 4'h7,
        OP_MULTIPLY_TO_GENERAL_REGISTER = 4'h8,
        OP_MULTIPLY_TO_ACCUMULATOR      = 4'h9,
        OP_MULTIPLY_ADD_ACCUMULATE      = 4'hA,
        OP_MULTIPLY_SUBTRACT_ACCUMULATE = 4'hB,
        OP_DIVIDE                       = 4'hC
    } fspc_op_t;
endpackage : fspc_pkg

// ---- dv/fspc_mem_model.sv ----
/* Cache arrays and bus side facing the pipeline control.
   Assumes the bench fills prog and sets the miss and bus controls. */
`timescale 1ns/1ps
`default_nettype none
module fspc_mem_model (
    input  wire logic        clock_in,
    input  wire logic [31:0] fetch_addr_in,
    output logic             icache_hit_out,
    output logic [31:0]      icache_data_out,
    output logic             dcache_hit_out,
    output logic [31:0]      dcache_rdata_out,
    input  wire logic        bus_req_in,
    input  wire logic        bus_is_data_in,
    input  wire logic [31:0] bus_addr_in,
    output logic             bus_busy_out,
    output logic             bus_rdata_valid_out = 1'b0,
    output logic [31:0]      bus_rdata_out
);
    localparam logic [31:0] CACHE_WORD = 32'h4433_2211;
    localparam logic [31:0] BUS_WORD   = 32'h8877_6655;
    logic [31:0] prog [0:31];
    logic [31:0] imiss_addr = 32'hFFFF_FFFF;
    logic        dmiss      = 1'b0;
    logic        bad_req    = 1'b0;
    logic        req_data   = 1'b0;
    logic [31:0] req_addr   = 32'h0000_0000;
    logic [31:0] last       = 32'h0000_0000;
    int          cyc        = 0;
    int          busy_until = 0;
    int          lat        = 1;
    int          wait_cnt   = 0;
    int          req_cnt    = 0;
    assign icache_hit_out   = fetch_addr_in !== imiss_addr;
    assign icache_data_out  = prog[fetch_addr_in[6:2]];
    assign dcache_hit_out   = !dmiss;
    assign dcache_rdata_out = CACHE_WORD;
    assign bus_busy_out     = busy_until > cyc;
    // Released data lines show a changing pattern, never the last word
    assign bus_rdata_out    = !bus_rdata_valid_out ? ~last :
                              req_data ? BUS_WORD : prog[req_addr[6:2]];
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        bus_rdata_valid_out <= 1'b0;
        last <= bus_rdata_out;
        if (bus_req_in === 1'b1) begin
            bad_req <= bad_req | bus_busy_out;
            req_data <= bus_is_data_in;
            req_addr <= bus_addr_in;
            req_cnt <= req_cnt + 1;
            wait_cnt <= lat;
        end else if (wait_cnt == 1) begin
            bus_rdata_valid_out <= 1'b1;
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule : fspc_mem_model
`default_nettype wire

// ---- dv/tb.sv ----
/* Self-checking bench for the pipeline control core.
   Assumes the memory model answers hits in the same cycle. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fspc_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        fetch_req_out, icache_hit_in, dcache_hit_in, bus_req_out;
    logic        bus_is_data_out, bus_busy_in, bus_rdata_valid_in, rf_wr_en_out, dcache_wr_out;
    logic [4:0]  rf_wr_idx_out;
    logic [31:0] fetch_addr_out, icache_data_in, dcache_addr_out, dcache_rdata_in;
    logic [31:0] bus_addr_out, bus_rdata_in, rf_wr_data_out, dcache_wdata_out;
    logic [31:0] accumulator_high_out, accumulator_low_out, w1, w2;
    logic [63:0] pr;
    logic [31:0] pg [8];
    logic [31:0] rf_sh [32];
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          wr_cnt    = 0;
    always #2 clock_in = ~clock_in;
    fspc_core u_dut (.clock_in, .rst_b_in, .fetch_req_out, .fetch_addr_out,
        .icache_hit_in, .icache_data_in, .dcache_rd_out(), .dcache_wr_out,
        .dcache_addr_out, .dcache_wdata_out, .dcache_hit_in, .dcache_rdata_in,
        .bus_req_out, .bus_is_data_out, .bus_addr_out, .bus_busy_in,
        .bus_rdata_valid_in, .bus_rdata_in, .rf_wr_en_out, .rf_wr_idx_out,
        .rf_wr_data_out, .accumulator_high_out, .accumulator_low_out);
    fspc_mem_model u_mem (.clock_in, .fetch_addr_in(fetch_addr_out),
        .icache_hit_out(icache_hit_in), .icache_data_out(icache_data_in),
        .dcache_hit_out(dcache_hit_in), .dcache_rdata_out(dcache_rdata_in),
        .bus_req_in(bus_req_out), .bus_is_data_in(bus_is_data_out),
        .bus_addr_in(bus_addr_out), .bus_busy_out(bus_busy_in),
        .bus_rdata_valid_out(bus_rdata_valid_in), .bus_rdata_out(bus_rdata_in));
    always @(posedge clock_in) begin
        if (rst_b_in !== 1'b1) begin
            wr_cnt <= 0;
            for (int i = 0; i < 32; i++) rf_sh[i] <= 32'h0000_0000;
        end else if (rf_wr_en_out === 1'b1) begin
            rf_sh[rf_wr_idx_out] <= rf_wr_data_out;
            wr_cnt <= wr_cnt + 1;
        end
        if (dcache_wr_out === 1'b1) rf_sh[0] <= dcache_addr_out + dcache_wdata_out;
    end
    function automatic logic [31:0] enc(fspc_op_t op, int rs, int rt, int rd, int imm);
        return {op, 2'h0, rs[4:0], rt[4:0], rd[4:0], 11'h000} | {16'h0000, imm[15:0]};
    endfunction : enc
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Reload program, restart pipe, wait for nw register writes
    task automatic run(int nw);
        int k;
        for (k = 0; k < 32; k++) u_mem.prog[k] = (k < 8) ? pg[k] : 32'h0000_0000;
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        k = 0;
        while (wr_cnt < nw && k < 400) begin
            @(posedge clock_in);
            k++;
        end
        repeat (8) @(posedge clock_in);
        check("write count", 32'(nw), 32'(wr_cnt));
    endtask : run
    task automatic wait_acc(logic [31:0] hi, logic [31:0] lo);
        int k;
        k = 0;
        while (!(accumulator_high_out === hi && accumulator_low_out === lo) && k < 200) begin
            @(posedge clock_in);
            k++;
        end
        check("acc high", hi, accumulator_high_out);
        check("acc low", lo, accumulator_low_out);
    endtask : wait_acc
    task automatic t_bypass;
        w1 = u_mem.CACHE_WORD;
        w2 = w1 >> 8;
        pg = '{enc(OP_LOAD, 0, 1, 0, 0), enc(OP_LOAD, 0, 2, 0, 1), enc(OP_ADD, 1, 2, 3, 0),
               enc(OP_SUB, 3, 1, 4, 0), enc(OP_AND, 3, 1, 5, 0), enc(OP_OR, 3, 2, 6, 0),
               enc(OP_STORE, 3, 2, 0, 8), 32'h0};
        run(6);
        check("r1", w1, rf_sh[1]);
        check("r2", w2, rf_sh[2]);
        check("r3", w1 + w2, rf_sh[3]);
        check("r4", w2, rf_sh[4]);
        check("r5", (w1 + w2) & w1, rf_sh[5]);
        check("r6", (w1 + w2) | w2, rf_sh[6]);
        check("store", w1 + 2 * w2 + 8, rf_sh[0]);
        $display("t_bypass done");
    endtask : t_bypass
    task automatic t_dmiss;
        w1 = u_mem.BUS_WORD >> 16;
        u_mem.dmiss = 1'b1;
        u_mem.lat = 5;
        u_mem.busy_until = u_mem.cyc + 10;
        pg = '{enc(OP_LOAD, 0, 1, 0, 2), enc(OP_ADD, 1, 1, 2, 0), 32'h0, 32'h0,
               32'h0, 32'h0, 32'h0, 32'h0};
        run(2);
        u_mem.dmiss = 1'b0;
        check("r1", w1, rf_sh[1]);
        check("r2", w1 + w1, rf_sh[2]);
        check("req addr", 32'h2, u_mem.req_addr);
        check("req data", 32'h1, 32'(u_mem.req_data));
        check("req while busy", 32'h0, 32'(u_mem.bad_req));
        $display("t_dmiss done");
    endtask : t_dmiss
    task automatic t_imiss;
        w1 = u_mem.CACHE_WORD;
        u_mem.imiss_addr = 32'h4;
        u_mem.lat = 3;
        pg = '{enc(OP_LOAD, 0, 1, 0, 0), enc(OP_ADD, 1, 1, 2, 0), 32'h0, 32'h0,
               32'h0, 32'h0, 32'h0, 32'h0};
        run(2);
        u_mem.imiss_addr = 32'hFFFF_FFFF;
        check("r2", w1 + w1, rf_sh[2]);
        check("req addr", 32'h4, u_mem.req_addr);
        check("req data", 32'h0, 32'(u_mem.req_data));
        $display("t_imiss done");
    endtask : t_imiss
    task automatic t_branch;
        w1 = u_mem.CACHE_WORD;
        pg = '{enc(OP_BRANCH_EQ, 0, 0, 0, 2), enc(OP_LOAD, 0, 1, 0, 0),
               enc(OP_LOAD, 0, 2, 0, 0), enc(OP_ADD, 1, 1, 3, 0), 32'h0, 32'h0, 32'h0, 32'h0};
        run(2);
        check("r2 skipped", 32'h0, rf_sh[2]);
        check("r3", w1 + w1, rf_sh[3]);
        $display("t_branch done");
    endtask : t_branch
    task automatic t_muldiv;
        w1 = u_mem.CACHE_WORD;
        w2 = w1 >> 24;
        pg = '{enc(OP_LOAD, 0, 1, 0, 0), enc(OP_LOAD, 0, 2, 0, 3),
               enc(OP_MULTIPLY_TO_GENERAL_REGISTER, 1, 2, 3, 0),
               enc(OP_MULTIPLY_TO_GENERAL_REGISTER, 1, 1, 4, 0), enc(OP_ADD, 3, 4, 5, 0),
               enc(OP_MULTIPLY_TO_ACCUMULATOR, 2, 2, 0, 0),
               enc(OP_MULTIPLY_ADD_ACCUMULATE, 2, 2, 0, 0),
               enc(OP_MULTIPLY_SUBTRACT_ACCUMULATE, 2, 1, 0, 0)};
        run(5);
        check("r3", w1 * w2, rf_sh[3]);
        check("r4", w1 * w1, rf_sh[4]);
        check("r5", w1 * w2 + w1 * w1, rf_sh[5]);
        pr = 64'(2 * w2 * w2) - 64'(w1) * w2;
        wait_acc(pr[63:32], pr[31:0]);
        pg[7] = enc(OP_DIVIDE, 1, 2, 0, 0);
        pg[5] = 32'h0;
        pg[6] = 32'h0;
        run(5);
        wait_acc(w1 % w2, w1 / w2);
        $display("t_muldiv done");
    endtask : t_muldiv
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge clock_in);
        t_bypass();
        t_dmiss();
        t_imiss();
        t_branch();
        t_muldiv();
        test_done();
    end
    // Six short programs need a few hundred cycles; allow far more
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule : tb
`default_nettype wire
